// ### hdl/exec_core.sv
// Execution core for a subset of an 8-bit accumulator machine.
// Assumes a valid instruction is presented with instr_valid_in; it is taken only when ready.
`timescale 1ns/10ps
`default_nettype none
`include "exec_params.svh"

// Operation
// - Power-down halts, stops clock, clears watchdog, sets power down flag, clears timeout, pc+1.
// - Increment memory writes byte plus one back to same location.
// - Direct jump loads pc with instruction address, flags unchanged.
// - Memory to accumulator copy, memory and flags unchanged.
// - Immediate load puts 8-bit constant in accumulator, flags unchanged.
// - Accumulator to memory store, accumulator and flags unchanged.
// - No operation changes nothing except pc plus one and the watchdog and prescaler counts.
// - Subroutine return pops pc, takes two cycles, flags unchanged.
// - Return with constant pops pc and loads accumulator with immediate.
// - Interrupt return pops pc and sets global interrupt enable.
// - Rotate left memory moves bit i to i+1, bit 7 to bit 0.
// - Rotate left to accumulator writes rotated byte, memory kept.
module exec_core (
    input  wire logic                     clock_in,
    input  wire logic                     srst_in,
    input  wire logic                     instr_valid_in,
    input  wire exec_pkg::instr_t         instr_in,
    input  wire logic                     call_push_in,
    input  wire logic                     wake_in,
    output logic                          instr_ready_out,
    output logic [`PC_W-1:0]              pc_out,
    output logic [7:0]                    acc_out,
    output exec_pkg::flags_t              flags_out,
    output logic                          halted_out,
    output logic                          sys_clock_en_out
);
    import exec_pkg::*;

    // ********************************
    // State
    // ********************************
    logic [7:0]              dmem_reg [`DMEM_DEPTH];
    logic [`PC_W-1:0]        stack_reg [`STACK_DEPTH];
    logic [`SP_W-1:0]        sp_reg;
    logic [`PC_W-1:0]        pc_reg;
    logic [7:0]              acc_reg;
    flags_t                  flags_reg;
    logic                    halted_reg;
    logic [1:0]              cyc_reg;
    logic [`WATCHDOG_W-1:0]  watchdog_counter;
    logic [`PSC_W-1:0]       prescaler_reg;
    logic [7:0]              mem_byte;
    logic [7:0]              or_mem;
    logic [7:0]              inc_byte;
    logic [7:0]              rol_byte;
    logic [`SP_W-1:0]        sp_top;
    logic                    fire;

    assign mem_byte = dmem_reg[instr_in.addr];
    assign inc_byte = mem_byte + `BYTE_ONE;
    assign or_mem   = acc_reg | mem_byte;
    assign sp_top   = sp_reg - `SP_STEP;
    assign fire     = instr_valid_in && instr_ready_out && !halted_reg;

    genvar gi;
    generate
        for (gi = 0; gi < 8; gi++) begin : g_rol
            assign rol_byte[(gi + 1) % 8] = mem_byte[gi];
        end
    endgenerate

    // ********************************
    // Cycle sequencing
    // ********************************
    // two-cycle return
    always_ff @(posedge clock_in) begin
        if (srst_in) begin
            cyc_reg         <= `CYC_ZERO;
            instr_ready_out <= 1'b1;
        end else if (fire && instr_in.op inside {subroutine_return_instr, return_with_imm_instr,
                                                 interrupt_return_instr}) begin
            cyc_reg         <= `CYC_ONE;
            instr_ready_out <= 1'b0;
        end else if (cyc_reg != `CYC_ZERO) begin
            cyc_reg         <= `CYC_ZERO;
            instr_ready_out <= 1'b1;
        end
    end

    // ********************************
    // Program counter and stack
    // ********************************
    always_ff @(posedge clock_in) begin
        if (srst_in) begin
            pc_reg <= `PC_RESET;
            sp_reg <= '0;
        end else if (fire) begin
            case (instr_in.op)
                direct_jump_instr: pc_reg <= instr_in.target;
                subroutine_return_instr, return_with_imm_instr, interrupt_return_instr: begin
                    pc_reg <= stack_reg[sp_top];
                    sp_reg <= sp_top;
                end
                default: pc_reg <= pc_reg + `PC_STEP;
            endcase
        end else if (call_push_in && !halted_reg) begin
            stack_reg[sp_reg] <= pc_reg;
            sp_reg            <= sp_reg + `SP_STEP;
        end
    end

    // ********************************
    // Accumulator
    // ********************************
    always_ff @(posedge clock_in) begin
        if (srst_in) begin
            acc_reg <= `BYTE_ZERO;
        end else if (fire) begin
            case (instr_in.op)
                increment_to_acc_instr:   acc_reg <= inc_byte;
                move_mem_to_acc_instr:    acc_reg <= mem_byte;
                move_imm_to_acc_instr:    acc_reg <= instr_in.imm;
                return_with_imm_instr:    acc_reg <= instr_in.imm;
                // or forms, memory destination keeps acc
                or_mem_to_acc_instr:      acc_reg <= or_mem;
                or_imm_to_acc_instr:      acc_reg <= acc_reg | instr_in.imm;
                rotate_left_to_acc_instr: acc_reg <= rol_byte;
                default:                  acc_reg <= acc_reg;
            endcase
        end
    end

    // ********************************
    // Data memory
    // ********************************
    always_ff @(posedge clock_in) begin
        if (fire) begin
            case (instr_in.op)
                increment_memory_instr:   dmem_reg[instr_in.addr] <= inc_byte;
                move_acc_to_mem_instr:    dmem_reg[instr_in.addr] <= acc_reg;
                or_to_memory_instr:       dmem_reg[instr_in.addr] <= or_mem;
                rotate_left_memory_instr: dmem_reg[instr_in.addr] <= rol_byte;
                default: ;
            endcase
        end
    end

    // ********************************
    // Flags, power down and watchdog
    // ********************************
    always_ff @(posedge clock_in) begin
        if (srst_in) begin
            flags_reg        <= '0;
            halted_reg       <= 1'b0;
            sys_clock_en_out <= 1'b1;
            watchdog_counter <= `WATCHDOG_ZERO;
            prescaler_reg    <= `PSC_ZERO;
        end else if (fire) begin
            {prescaler_reg, watchdog_counter} <= {prescaler_reg + `PSC_STEP,
                                                  watchdog_counter + `WATCHDOG_STEP};
            case (instr_in.op)
                halt_instr: begin
                    halted_reg                      <= 1'b1;
                    sys_clock_en_out                <= 1'b0;
                    watchdog_counter                <= `WATCHDOG_ZERO;
                    prescaler_reg                   <= `PSC_ZERO;
                    flags_reg.power_down_flag       <= 1'b1;
                    flags_reg.watchdog_timeout_flag <= 1'b0;
                end
                increment_memory_instr, increment_to_acc_instr:
                    flags_reg.zero_flag <= (inc_byte == `BYTE_ZERO);
                or_mem_to_acc_instr, or_to_memory_instr:
                    flags_reg.zero_flag <= (or_mem == `BYTE_ZERO);
                or_imm_to_acc_instr:
                    flags_reg.zero_flag <= ((acc_reg | instr_in.imm) == `BYTE_ZERO);
                interrupt_return_instr: flags_reg.global_interrupt_enable <= 1'b1;
                default: flags_reg <= flags_reg;
            endcase
        end else if (halted_reg && wake_in) begin
            halted_reg       <= 1'b0;
            sys_clock_en_out <= 1'b1;
        end
    end

    assign pc_out     = pc_reg;
    assign acc_out    = acc_reg;
    assign flags_out  = flags_reg;
    assign halted_out = halted_reg;

    // ********************************
    // Checks
    // ********************************
    sequence s_halt_taken;
        fire && instr_in.op == halt_instr;
    endsequence

    a_halt_pdf_set: assert property (@(posedge clock_in) disable iff (srst_in)
        s_halt_taken |=> flags_out.power_down_flag && !flags_out.watchdog_timeout_flag
                         && halted_out && !sys_clock_en_out
                         && watchdog_counter == `WATCHDOG_ZERO)
        else $error("power down entry wrong");
    a_jump_target: assert property (@(posedge clock_in) disable iff (srst_in)
        fire && instr_in.op == direct_jump_instr
        |=> pc_out == $past(instr_in.target) && $stable(flags_out))
        else $error("jump target wrong");
    a_mov_acc_load: assert property (@(posedge clock_in) disable iff (srst_in)
        fire && instr_in.op == move_mem_to_acc_instr
        |=> acc_out == $past(mem_byte) && $stable(flags_out))
        else $error("memory to acc wrong");
    a_imm_load: assert property (@(posedge clock_in) disable iff (srst_in)
        fire && instr_in.op == move_imm_to_acc_instr |=> acc_out == $past(instr_in.imm))
        else $error("immediate load wrong");
    a_idle_pc_step: assert property (@(posedge clock_in) disable iff (srst_in)
        fire && instr_in.op == no_operation_instr |=> pc_out == $past(pc_out) + `PC_STEP
                                         && $stable(acc_out) && $stable(flags_out))
        else $error("idle instruction changed state");
    a_return_two_cyc: assert property (@(posedge clock_in) disable iff (srst_in)
        fire && instr_in.op == subroutine_return_instr |=> !instr_ready_out ##1 instr_ready_out)
        else $error("return not two cycles");
    a_int_return_enable: assert property (@(posedge clock_in) disable iff (srst_in)
        fire && instr_in.op == interrupt_return_instr |=> flags_out.global_interrupt_enable)
        else $error("interrupt return enable wrong");
    a_rotate_acc_value: assert property (@(posedge clock_in) disable iff (srst_in)
        fire && instr_in.op == rotate_left_to_acc_instr
        |=> acc_out == {$past(mem_byte[6:0]), $past(mem_byte[7])})
        else $error("rotate to acc wrong");
    a_inc_acc_zero: assert property (@(posedge clock_in) disable iff (srst_in)
        fire && instr_in.op == increment_to_acc_instr
        |=> flags_out.zero_flag == (acc_out == `BYTE_ZERO))
        else $error("increment zero flag wrong");
    a_or_mem_acc_kept: assert property (@(posedge clock_in) disable iff (srst_in)
        fire && instr_in.op == or_to_memory_instr |=> $stable(acc_out))
        else $error("or into memory changed acc");
endmodule // exec_core
`default_nettype wire

// ### hdl/exec_params.svh
// Constants for the instruction execution block.
// Assumes inclusion by exec_pkg and the execution core only.
`ifndef EXEC_PARAMS_SVH
`define EXEC_PARAMS_SVH
`define PC_W         12
`define ADDR_W       8
`define DMEM_DEPTH   256
`define STACK_DEPTH  8
`define SP_W         3
`define PC_STEP      12'h001
`define SP_STEP      3'h1
`define BYTE_ONE     8'h01
`define BYTE_ZERO    8'h00
`define PC_RESET     12'h000
`define WATCHDOG_W    16
`define WATCHDOG_ZERO 16'h0000
`define WATCHDOG_STEP 16'h0001
`define PSC_W        8
`define PSC_ZERO     8'h00
`define PSC_STEP     8'h01
`define RETURN_CYCLES 2'h2
`define CYC_ONE      2'h1
`define CYC_ZERO     2'h0
`endif

// ### hdl/exec_pkg.sv
// Types for the instruction execution block.
// Assumes exec_params.svh is on the include path.
`default_nettype none
`include "exec_params.svh"
package exec_pkg;
    typedef enum logic [3:0] {
        halt_instr, increment_memory_instr, increment_to_acc_instr, direct_jump_instr,
        move_mem_to_acc_instr, move_imm_to_acc_instr, move_acc_to_mem_instr,
        no_operation_instr, or_mem_to_acc_instr, or_imm_to_acc_instr, or_to_memory_instr,
        subroutine_return_instr, return_with_imm_instr, interrupt_return_instr,
        rotate_left_memory_instr, rotate_left_to_acc_instr
    } opcode_t;

    typedef struct packed {
        opcode_t                 op;
        logic [`ADDR_W-1:0]      addr;
        logic [7:0]              imm;
        logic [`PC_W-1:0]        target;
    } instr_t;

    typedef struct packed {
        logic zero_flag;
        logic power_down_flag;
        logic watchdog_timeout_flag;
        logic global_interrupt_enable;
    } flags_t;
endpackage
`default_nettype wire

// ### verif/tb_exec_core.sv
// Self-checking bench for the execution core.
// Assumes exec_pkg is compiled first; memory is written before it is read.
`timescale 1ns/10ps
`default_nettype none
`define CHK(nm, e, g) begin comparisons++; if ((g) !== (e)) begin err_total++; \
    $display("[ERR] %s exp %h got %h", nm, e, g); end end

module tb_exec_core;
    import exec_pkg::*;
    logic        clock_in, srst_in, instr_valid_in, call_push_in, wake_in;
    instr_t      instr_in;
    logic        instr_ready_out, halted_out, sys_clock_en_out;
    logic [11:0] pc_out, ep, p0;
    logic [7:0]  acc_out, ea;
    flags_t      flags_out, ef;
    int          err_total, comparisons;

    exec_core dut (.clock_in(clock_in), .srst_in(srst_in), .instr_valid_in(instr_valid_in),
        .instr_in(instr_in), .call_push_in(call_push_in), .wake_in(wake_in),
        .instr_ready_out(instr_ready_out), .pc_out(pc_out), .acc_out(acc_out),
        .flags_out(flags_out), .halted_out(halted_out), .sys_clock_en_out(sys_clock_en_out));

    initial begin
        clock_in = 1'b0;
        forever #5 clock_in = ~clock_in;
    end

    // ****************************************
    // Shared tasks
    // ****************************************
    task automatic end_of_test;
        $display("err_total %0d comparisons %0d", err_total, comparisons);
        if (err_total == 0 && comparisons > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    task automatic issue(opcode_t op, logic [7:0] a, logic [7:0] i, logic [11:0] t);
        int n;
        n = 0;
        while (instr_ready_out !== 1'b1 && n < 20) begin
            @(posedge clock_in);
            #1;
            n++;
        end
        if (instr_ready_out !== 1'b1) begin
            err_total++;
            end_of_test;
        end
        instr_valid_in = 1'b1;
        instr_in = '{op: op, addr: a, imm: i, target: t};
        @(posedge clock_in);
        #1;
        instr_valid_in = 1'b0;
    endtask

    // Issue one instruction, then check acc, pc, flags and ready
    task automatic step(opcode_t op, logic [7:0] a, logic [7:0] i, logic [11:0] t,
                        logic [7:0] e_acc, logic [11:0] np);
        issue(op, a, i, t);
        if (op inside {subroutine_return_instr, return_with_imm_instr, interrupt_return_instr})
            `CHK("ready", 1'b0, instr_ready_out)
        @(posedge clock_in);
        #1;
        ep = np;
        ea = e_acc;
        `CHK("acc", ea, acc_out)
        `CHK("pc", ep, pc_out)
        `CHK("flags", ef, flags_out)
        `CHK("ready", 1'b1, instr_ready_out)
    endtask

    task automatic push_pc;
        call_push_in = 1'b1;
        @(posedge clock_in);
        #1;
        call_push_in = 1'b0;
    endtask

    // ****************************************
    // Scenarios
    // ****************************************
    task automatic t_moves;
        step(move_imm_to_acc_instr, 8'h00, 8'h5a, 12'h000, 8'h5a, ep + 12'h001);
        step(move_acc_to_mem_instr, 8'h10, 8'h00, 12'h000, 8'h5a, ep + 12'h001);
        step(move_imm_to_acc_instr, 8'h00, 8'h00, 12'h000, 8'h00, ep + 12'h001);
        step(move_mem_to_acc_instr, 8'h10, 8'h00, 12'h000, 8'h5a, ep + 12'h001);
    endtask

    task automatic t_inc;
        step(move_imm_to_acc_instr, 8'h00, 8'hff, 12'h000, 8'hff, ep + 12'h001);
        step(move_acc_to_mem_instr, 8'h11, 8'h00, 12'h000, 8'hff, ep + 12'h001);
        ef.zero_flag = 1'b1;
        step(increment_memory_instr, 8'h11, 8'h00, 12'h000, 8'hff, ep + 12'h001);
        step(move_mem_to_acc_instr, 8'h11, 8'h00, 12'h000, 8'h00, ep + 12'h001);
        ef.zero_flag = 1'b0;
        step(increment_to_acc_instr, 8'h11, 8'h00, 12'h000, 8'h01, ep + 12'h001);
        step(move_mem_to_acc_instr, 8'h11, 8'h00, 12'h000, 8'h00, ep + 12'h001);
    endtask

    task automatic t_or;
        ef.zero_flag = 1'b1;
        step(or_imm_to_acc_instr, 8'h00, 8'h00, 12'h000, 8'h00, ep + 12'h001);
        step(move_imm_to_acc_instr, 8'h00, 8'h0f, 12'h000, 8'h0f, ep + 12'h001);
        step(move_acc_to_mem_instr, 8'h12, 8'h00, 12'h000, 8'h0f, ep + 12'h001);
        step(move_imm_to_acc_instr, 8'h00, 8'h30, 12'h000, 8'h30, ep + 12'h001);
        ef.zero_flag = 1'b0;
        step(or_mem_to_acc_instr, 8'h12, 8'h00, 12'h000, 8'h3f, ep + 12'h001);
        step(or_imm_to_acc_instr, 8'h00, 8'h80, 12'h000, 8'hbf, ep + 12'h001);
        step(move_imm_to_acc_instr, 8'h00, 8'h40, 12'h000, 8'h40, ep + 12'h001);
        step(or_to_memory_instr, 8'h12, 8'h00, 12'h000, 8'h40, ep + 12'h001);
        step(move_mem_to_acc_instr, 8'h12, 8'h00, 12'h000, 8'h4f, ep + 12'h001);
    endtask

    task automatic t_rot;
        step(move_imm_to_acc_instr, 8'h00, 8'h81, 12'h000, 8'h81, ep + 12'h001);
        step(move_acc_to_mem_instr, 8'h13, 8'h00, 12'h000, 8'h81, ep + 12'h001);
        step(rotate_left_memory_instr, 8'h13, 8'h00, 12'h000, 8'h81, ep + 12'h001);
        step(move_mem_to_acc_instr, 8'h13, 8'h00, 12'h000, 8'h03, ep + 12'h001);
        step(rotate_left_to_acc_instr, 8'h13, 8'h00, 12'h000, 8'h06, ep + 12'h001);
        step(move_mem_to_acc_instr, 8'h13, 8'h00, 12'h000, 8'h03, ep + 12'h001);
    endtask

    task automatic t_jump_ret;
        step(direct_jump_instr, 8'h00, 8'h00, 12'habc, ea, 12'habc);
        step(no_operation_instr, 8'h00, 8'h00, 12'h000, ea, ep + 12'h001);
        p0 = ep;
        push_pc;
        step(no_operation_instr, 8'h00, 8'h00, 12'h000, ea, ep + 12'h001);
        push_pc;
        step(no_operation_instr, 8'h00, 8'h00, 12'h000, ea, ep + 12'h001);
        push_pc;
        step(direct_jump_instr, 8'h00, 8'h00, 12'h100, ea, 12'h100);
        ef.global_interrupt_enable = 1'b1;
        step(interrupt_return_instr, 8'h00, 8'h00, 12'h000, ea, p0 + 12'h002);
        step(return_with_imm_instr, 8'h00, 8'h77, 12'h000, 8'h77, p0 + 12'h001);
        step(subroutine_return_instr, 8'h00, 8'h00, 12'h000, 8'h77, p0);
    endtask

    task automatic t_halt;
        ef.power_down_flag = 1'b1;
        ef.watchdog_timeout_flag = 1'b0;
        step(halt_instr, 8'h00, 8'h00, 12'h000, ea, ep + 12'h001);
        `CHK("halted", 1'b1, halted_out)
        `CHK("clk_en", 1'b0, sys_clock_en_out)
        instr_valid_in = 1'b1;
        instr_in = '{op: move_imm_to_acc_instr, addr: 8'h00, imm: 8'h99, target: 12'h000};
        repeat (3) @(posedge clock_in);
        #1;
        instr_valid_in = 1'b0;
        `CHK("acc", ea, acc_out)
        `CHK("pc", ep, pc_out)
        `CHK("flags", ef, flags_out)
        wake_in = 1'b1;
        repeat (2) @(posedge clock_in);
        #1;
        wake_in = 1'b0;
        `CHK("halted", 1'b0, halted_out)
        `CHK("clk_en", 1'b1, sys_clock_en_out)
        step(no_operation_instr, 8'h00, 8'h00, 12'h000, ea, ep + 12'h001);
    endtask

    // ****************************************
    // Main sequence
    // ****************************************
    initial begin
        err_total = 0;
        comparisons = 0;
        srst_in = 1'b1;
        instr_valid_in = 1'b0;
        call_push_in = 1'b0;
        wake_in = 1'b0;
        instr_in = '0;
        ef = '0;
        ep = 12'h000;
        ea = 8'h00;
        repeat (5) @(posedge clock_in);
        #1;
        srst_in = 1'b0;
        `CHK("pc", ep, pc_out)
        `CHK("flags", ef, flags_out)
        `CHK("ready", 1'b1, instr_ready_out)
        `CHK("clk_en", 1'b1, sys_clock_en_out)
        t_moves;
        t_inc;
        t_or;
        t_rot;
        t_jump_ret;
        t_halt;
        end_of_test;
    end
endmodule // tb_exec_core
`default_nettype wire
